// ===== tb.sv
// self-checking bench of the variable width external bus
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic              i_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rv = 1'b0, lerr;
    logic              hold_n = 1'b1, program_width_select = 1'b0, wide = 1'b1, slow = 1'b0, prdy, perr, ack, rerr, rw, per_n;
    logic              doe_n, boe_n, gnt_n, rdy_n, a0_q = 1'b1;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, rdata, dout, mrd, rd;
    logic [23:0]       addr;
    logic [3:0]        sa, sb, seen_a, seen_b;
    vwb_pkg::vwb_req_s req = '0;
    int                err_count = 0, checks_done = 0, cyc = 0, pieces = 0, acks = 0, n0;
    wire logic [31:0]  dbus = !doe_n ? dout : mrd;  // shared data wire
    always #25 i_clk = !i_clk;
    vwb_ext_bus dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr),
        .i_req_valid(rv), .i_req(req), .o_req_ack(ack), .o_req_err(rerr), .o_req_rdata(rdata),
        .i_hold_n(hold_n), .i_ready_n(rdy_n), .i_program_width_select(program_width_select), .i_data(dbus), .o_addr(addr),
        .o_data(dout), .o_data_oe_n(doe_n), .o_bus_oe_n(boe_n), .o_read_write(rw), .o_bank_a_strobe_set(sa),
        .o_bank_b_strobe_set(sb), .o_peripheral_strobe_n(per_n), .o_bus_release_grant_n(gnt_n),
        .o_bus_clock_phase_one(), .o_bus_clock_phase_three());
    vwb_mem_model mem_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rw(rw), .i_per_n(per_n), .i_wide(wide),
        .i_slow(slow), .i_addr(addr), .i_wdata(dbus), .i_sa(sa), .i_sb(sb), .o_ready_n(rdy_n), .o_rdata(mrd));
    // pin monitor and run limit
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        a0_q <= sa[0];
        if (a0_q && !sa[0]) pieces <= pieces + 1;
        if (sa != 4'hf) seen_a <= sa;
        if (sb != 4'hf) seen_b <= sb;
        if (ack) acks <= acks + 1;
        if (cyc == 20000) begin err_count++; end_sim(); end
    end
    task automatic end_sim();
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] exp, got);
        #1;
        checks_done++;
        if (got !== exp) begin err_count++; $display("Error %s expected %h seen %h", nm, exp, got); end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        while (prdy !== 1'b1) @(posedge i_clk);
        rd = prdata; lerr = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic xfer(input logic [23:0] a, input logic w, p, input logic [31:0] d);
        @(posedge i_clk);
        rv <= 1'b1; req <= '{a, d, w, p};
        @(posedge i_clk);
        while (ack !== 1'b1 && rerr !== 1'b1) @(posedge i_clk);
        rd = rdata; lerr = rerr;
        rv <= 1'b0;
    endtask : xfer
    // main sequence
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        apb(1'b0, 8'h00, 32'h0); chk("ctl a", 32'h57, rd);
        apb(1'b0, 8'h04, 32'h0); chk("ctl b", 32'h57, rd);
        apb(1'b0, 8'h10, 32'h0); chk("unmapped", 32'h1, {31'h0, lerr});
        apb(1'b1, 8'h00, 32'h50);
        xfer(24'h000005, 1'b1, 1'b0, 32'hcafef00d);
        xfer(24'h000005, 1'b0, 1'b0, 32'h0); chk("word", 32'hcafef00d, rd);
        chk("word lanes", 32'h0, {28'h0, seen_a});
        apb(1'b1, 8'h00, 32'h10);
        xfer(24'h000002, 1'b0, 1'b0, 32'h0); chk("byte", 32'h33, rd);
        chk("byte lanes", 32'hb, {28'h0, seen_a});
        apb(1'b1, 8'h00, 32'h40);
        wide <= 1'b0; pieces = 0;
        xfer(24'h000001, 1'b0, 1'b0, 32'h0); chk("pieces", 32'h4, 32'(pieces));
        chk("addr pins", 32'he, {28'h0, seen_a});
        xfer(24'h000001, 1'b0, 1'b1, 32'h0); chk("fetch refused", 32'h1, {31'h0, lerr});
        wide <= 1'b1; slow <= 1'b1;
        xfer(24'h900000, 1'b0, 1'b0, 32'h0); chk("bank b", 32'h44332211, rd);
        chk("bank b lanes", 32'h0, {28'h0, seen_b});
        xfer(24'h800000, 1'b0, 1'b0, 32'h0); chk("io word", 32'h44332211, rd);
        apb(1'b1, 8'h00, 32'h50);
        hold_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk("grant", 32'h0, {31'h0, gnt_n});
        chk("bus float", 32'h1, {31'h0, boe_n});
        n0 = acks;
        fork
            xfer(24'h000006, 1'b0, 1'b0, 32'h0);
            begin
                repeat (20) @(posedge i_clk);
                chk("held", 32'(n0), 32'(acks));
                apb(1'b1, 8'h00, 32'hd0);
            end
        join
        chk("lockout grant", 32'h1, {31'h0, gnt_n});
        chk("acks", 32'(n0 + 1), 32'(acks));
        hold_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        program_width_select <= 1'b1; i_rst_n <= 1'b0; wide <= 1'b0; slow <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        apb(1'b0, 8'h00, 32'h0); chk("ctl a narrow", 32'h4f, rd);
        pieces = 0;
        xfer(24'h000002, 1'b0, 1'b1, 32'h0); chk("half fetches", 32'h2, 32'(pieces));
        chk("half lanes", 32'hc, {28'h0, seen_a});
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ===== vwb_ext_bus.sv
// variable width external bus interface
//
// What this block does
// - read/write line high on reads, low on writes
// - 24-bit address port, can float
// - 32-bit two-way data port, can float
// - lane-3 pin: enable on 32-bit memory, else address bit
// - lane-2 pin: byte enable on 32-bit memory, address bit on 8-bit
// - lane-0 pin is always a byte enable; lane-1 pin is one on 16 or 32-bit memory, else held high
// - transfer ends only after the ready input is asserted
// - release request low: finish transfer, then float all bus outputs
// - no transfers until request high or lockout bit set
// - grant low once bus is floated and transfers suspended
// - grant high when request high or lockout bit set
// - width pin low: 32-bit fetch; high: two 16-bit fetches
// - width pin at reset sets both bank control reset values
// - each bank strobe has wait, width and data size settings; the peripheral strobe has waits only
// - both banks carry 8, 16 or 32-bit data reads and writes
// - program fetch only from 16 or 32-bit memory
// - two bus clock outputs at half the input clock rate
// - a strobe set activates for accesses inside its range
// - data size may differ from physical memory width
// - peripheral strobe: single, 32-bit only, slower timing
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vwb_ext_bus (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // apb slave
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    // cpu or dma request
    input  wire logic             i_req_valid,
    input  wire vwb_pkg::vwb_req_s i_req,
    output logic                  o_req_ack,
    output logic                  o_req_err,
    output logic      [31:0]      o_req_rdata,
    // external pins, inputs
    input  wire logic             i_hold_n,
    input  wire logic             i_ready_n,
    input  wire logic             i_program_width_select,
    input  wire logic [31:0]      i_data,
    // external pins, outputs
    output logic      [23:0]      o_addr,
    output logic      [31:0]      o_data,
    output logic                  o_data_oe_n,
    output logic                  o_bus_oe_n,
    output logic                  o_read_write,
    output logic      [3:0]       o_bank_a_strobe_set,
    output logic      [3:0]       o_bank_b_strobe_set,
    output logic                  o_peripheral_strobe_n,
    output logic                  o_bus_release_grant_n,
    output logic                  o_bus_clock_phase_one,
    output logic                  o_bus_clock_phase_three
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // byte address of an item
    function automatic logic [25:0] f_byte_addr(input logic [23:0] a, input logic [1:0] ds);
        f_byte_addr = (ds == vwb_pkg::VWB_W8)  ? {2'h0, a} :
                      (ds == vwb_pkg::VWB_W16) ? {1'b0, a, 1'b0} : {a, 2'h0};
    endfunction : f_byte_addr

    // lane bits within one memory word
    function automatic logic [1:0] f_lane_mask(input logic [1:0] pw);
        f_lane_mask = (pw == vwb_pkg::VWB_W32) ? 2'h3 : (pw == vwb_pkg::VWB_W16) ? 2'h1 : 2'h0;
    endfunction : f_lane_mask

    // byte lanes of a piece of size gw at offs
    function automatic logic [3:0] f_lanes(input logic [1:0] offs, input logic [1:0] gw);
        logic [3:0] base;
        base = (gw == vwb_pkg::VWB_W8) ? 4'h1 : (gw == vwb_pkg::VWB_W16) ? 4'h3 : 4'hf;
        f_lanes = 4'(base << offs);
    endfunction : f_lanes

    // bit mask of a piece of size gw
    function automatic logic [31:0] f_bits(input logic [1:0] gw);
        f_bits = (gw == vwb_pkg::VWB_W8)  ? 32'h0000_00ff :
                 (gw == vwb_pkg::VWB_W16) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction : f_bits

    // index of the last piece of an item
    function automatic logic [1:0] f_last(input logic [1:0] ds, input logic [1:0] pw);
        f_last = (ds > pw) ? 2'((3'h1 << (ds - pw)) - 3'h1) : 2'h0;
    endfunction : f_last

    // code 3 is held as 32 bits
    function automatic logic [1:0] f_clamp(input logic [1:0] c);
        f_clamp = (c > vwb_pkg::VWB_W32) ? vwb_pkg::VWB_W32 : c;
    endfunction : f_clamp

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vwb_pkg::vwb_state_e state_r;
    vwb_pkg::vwb_state_e state_nxt;
    vwb_pkg::vwb_ctl_s   ctl_a_r;
    vwb_pkg::vwb_ctl_s   ctl_b_r;
    vwb_pkg::vwb_ctl_s   ctl_io_r;
    vwb_pkg::vwb_req_s   req_r;
    vwb_pkg::vwb_sel_e   sel_r;
    logic [25:0]         base_r;
    logic [1:0]          ds_r;
    logic [1:0]          pw_r;
    logic [1:0]          piece_r;
    logic [1:0]          last_r;
    logic [3:0]          wait_r;
    logic [31:0]         acc_r;
    logic [1:0]          init_cnt_r;
    logic                init_done_r;
    logic                hold_s;
    logic                ready_s;
    logic                program_width_select_s;
    logic [31:0]         din_s;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    vwb_sync #(.W(3), .RST(3'h6)) u_ctl_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_hold_n, i_ready_n, i_program_width_select}),
        .o_q     ({hold_s, ready_s, program_width_select_s})
    );

    vwb_sync #(.W(32), .RST(32'h0)) u_data_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_data),
        .o_q     (din_s)
    );

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // range decode
    wire                 sel_io_w = (i_req.addr[23:20] == vwb_pkg::VWB_IO_REGION);
    wire                 sel_b_w  = !sel_io_w && i_req.addr[vwb_pkg::VWB_BANK_B_BIT];
    vwb_pkg::vwb_ctl_s   ctl_w;
    assign ctl_w = sel_io_w ? ctl_io_r : (sel_b_w ? ctl_b_r : ctl_a_r);
    vwb_pkg::vwb_ctl_s   ctl_s_w;  // control of the captured strobe
    assign ctl_s_w = (sel_r == vwb_pkg::VWB_SEL_IO) ? ctl_io_r : (sel_r == vwb_pkg::VWB_SEL_B) ? ctl_b_r : ctl_a_r;
    // peripheral is always 32-bit item on 32-bit memory
    wire [1:0]           ds_w = (i_req.prog || sel_io_w) ? vwb_pkg::VWB_W32 : ctl_w.dsize;
    // program fetch width follows the width pin
    wire [1:0]           pw_w = sel_io_w ? vwb_pkg::VWB_W32 :
                                i_req.prog ? (program_width_select_s ? vwb_pkg::VWB_W16 : vwb_pkg::VWB_W32) :
                                ctl_w.pwidth;
    // no fetch from a bank set to 8-bit memory
    wire                 bad_w = i_req.prog && !sel_io_w && (ctl_w.pwidth == vwb_pkg::VWB_W8);
    wire                 hold_lock_w = !hold_s && !ctl_a_r.lockout;
    wire                 take_w = (state_r == vwb_pkg::ST_IDLE) && init_done_r && i_req_valid &&
                                  !o_req_ack && !o_req_err && !hold_lock_w;

    // ------------------------------------------------------------
    // piece datapath
    // ------------------------------------------------------------
    // pieces step by one memory width
    wire [25:0]          b_w    = 26'(base_r + (26'(piece_r) << pw_r));
    wire [1:0]           offs_w = b_w[1:0] & f_lane_mask(pw_r);
    // piece size is the smaller of item and memory
    wire [1:0]           gw_w   = (ds_r < pw_r) ? ds_r : pw_r;
    wire [3:0]           en_w   = f_lanes(offs_w, gw_w);
    wire [4:0]           sh_w   = 5'({piece_r, 3'h0} << pw_r);
    wire [31:0]          wpc_w  = (req_r.wdata >> sh_w) << {offs_w, 3'h0};
    wire [31:0]          rpc_w  = ((din_s >> {offs_w, 3'h0}) & f_bits(gw_w)) << sh_w;
    wire                 last_w = (piece_r == last_r);
    // finish only after waits and ready
    wire                 done_w = (state_r == vwb_pkg::ST_STROBE) && (wait_r == 4'h0) && !ready_s;

    wire [3:0]           lanes_w = (pw_r == vwb_pkg::VWB_W8)  ? {b_w[1], b_w[0], 1'b1, ~en_w[0]} :
                                   (pw_r == vwb_pkg::VWB_W16) ? {b_w[1], 1'b1, ~en_w[1:0]} : ~en_w;
    wire                 active_w = (state_r == vwb_pkg::ST_SETUP) || (state_r == vwb_pkg::ST_STROBE);
    wire                 strobe_w = (state_r == vwb_pkg::ST_STROBE);

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // next state of the bus sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            vwb_pkg::ST_IDLE: begin
                if (init_done_r && hold_lock_w)
                    state_nxt = vwb_pkg::ST_RELEASED;
                else if (take_w && !bad_w)
                    state_nxt = vwb_pkg::ST_SETUP;
            end
            vwb_pkg::ST_SETUP:
                state_nxt = vwb_pkg::ST_STROBE;
            vwb_pkg::ST_STROBE: begin
                if (done_w)
                    state_nxt = last_w ? vwb_pkg::ST_IDLE : vwb_pkg::ST_SETUP;
            end
            vwb_pkg::ST_RELEASED: begin
                // request high or lockout ends the release
                if (hold_s || ctl_a_r.lockout)
                    state_nxt = vwb_pkg::ST_IDLE;
            end
            default:
                state_nxt = vwb_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            state_r <= vwb_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // request capture and piece stepping
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_r   <= '0;
            sel_r   <= vwb_pkg::VWB_SEL_A;
            base_r  <= 26'h0;
            ds_r    <= vwb_pkg::VWB_W32;
            pw_r    <= vwb_pkg::VWB_W32;
            last_r  <= 2'h0;
            piece_r <= 2'h0;
            wait_r  <= 4'h0;
            acc_r   <= 32'h0;
        end else if (take_w) begin
            req_r   <= i_req;
            sel_r   <= sel_io_w ? vwb_pkg::VWB_SEL_IO : (sel_b_w ? vwb_pkg::VWB_SEL_B : vwb_pkg::VWB_SEL_A);
            base_r  <= f_byte_addr(i_req.addr, ds_w);
            ds_r    <= ds_w;
            pw_r    <= pw_w;
            last_r  <= f_last(ds_w, pw_w);
            piece_r <= 2'h0;
            acc_r   <= 32'h0;
        end else if (state_r == vwb_pkg::ST_SETUP) begin
            wait_r  <= {1'b0, ctl_s_w.waits} + vwb_pkg::VWB_MIN_STROBE +
                       ((sel_r == vwb_pkg::VWB_SEL_IO) ? vwb_pkg::VWB_IO_EXTRA : 4'h0);
        end else if (state_r == vwb_pkg::ST_STROBE) begin
            if (wait_r != 4'h0)
                wait_r <= wait_r - 4'h1;
            if (done_w) begin
                acc_r   <= acc_r | rpc_w;
                piece_r <= piece_r + 2'h1;
            end
        end
    end

    // requester answer pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_req_ack   <= 1'b0;
            o_req_err   <= 1'b0;
            o_req_rdata <= 32'h0;
        end else begin
            o_req_ack <= done_w && last_w;
            o_req_err <= take_w && bad_w;
            if (done_w && last_w)
                o_req_rdata <= acc_r | rpc_w;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // bus pins, all registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr                <= 24'h0;
            o_data                <= 32'h0;
            o_data_oe_n           <= 1'b1;
            o_bus_oe_n            <= 1'b0;
            o_read_write          <= 1'b1;
            o_bank_a_strobe_set   <= 4'hf;
            o_bank_b_strobe_set   <= 4'hf;
            o_peripheral_strobe_n <= 1'b1;
            o_bus_release_grant_n <= 1'b1;
        end else begin
            o_addr <= b_w[25:2];
            o_data <= wpc_w;
            o_data_oe_n <= !(active_w && req_r.write);
            o_bus_oe_n <= (state_r == vwb_pkg::ST_RELEASED);
            o_bus_release_grant_n <= (state_r != vwb_pkg::ST_RELEASED);
            // high on read, low on write
            o_read_write <= !(active_w && req_r.write);
            o_bank_a_strobe_set <= (strobe_w && sel_r == vwb_pkg::VWB_SEL_A) ? lanes_w : 4'hf;
            o_bank_b_strobe_set <= (strobe_w && sel_r == vwb_pkg::VWB_SEL_B) ? lanes_w : 4'hf;
            o_peripheral_strobe_n <= !(strobe_w && sel_r == vwb_pkg::VWB_SEL_IO);
        end
    end

    // two antiphase bus clocks at half rate
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_clock_phase_one   <= 1'b0;
            o_bus_clock_phase_three <= 1'b1;
        end else begin
            o_bus_clock_phase_one   <= !o_bus_clock_phase_one;
            o_bus_clock_phase_three <= o_bus_clock_phase_one;
        end
    end

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    wire        apb_wr_w  = i_psel && i_penable && i_pwrite && o_pready;
    wire        hit_a_w   = (i_paddr == vwb_pkg::VWB_OFF_CTL_A);
    wire        hit_b_w   = (i_paddr == vwb_pkg::VWB_OFF_CTL_B);
    wire        hit_io_w  = (i_paddr == vwb_pkg::VWB_OFF_CTL_IO);
    wire        hit_st_w  = (i_paddr == vwb_pkg::VWB_OFF_STATUS);
    wire        mapped_w  = hit_a_w || hit_b_w || hit_io_w || hit_st_w;
    wire [7:0]  status_w  = {3'h0, (state_r == vwb_pkg::ST_RELEASED), active_w, program_width_select_s, 1'b0, init_done_r};
    wire [7:0]  rsel_w    = hit_a_w ? ctl_a_r : hit_b_w ? ctl_b_r : hit_io_w ? ctl_io_r : status_w;
    vwb_pkg::vwb_ctl_s wctl_w;
    assign wctl_w = '{i_pwdata[7], f_clamp(i_pwdata[6:5]), f_clamp(i_pwdata[4:3]), i_pwdata[2:0]};
    // reset value chosen by the width strap
    vwb_pkg::vwb_ctl_s rst_ctl_w;
    assign rst_ctl_w = program_width_select_s ? vwb_pkg::VWB_CTL_RST_16 : vwb_pkg::VWB_CTL_RST_32;
    wire        load_w    = !init_done_r && (init_cnt_r == vwb_pkg::VWB_INIT_LOAD);

    // apb answer: one wait-free access phase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !mapped_w;
            o_prdata  <= (i_psel && !i_penable && !i_pwrite && mapped_w) ? {24'h0, rsel_w} : 32'h0;
        end
    end

    // strap capture after reset release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            init_cnt_r  <= 2'h0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            init_cnt_r  <= init_cnt_r + 2'h1;
            init_done_r <= load_w;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_a_r  <= '0;
            ctl_b_r  <= '0;
            ctl_io_r <= '0;
        end else if (load_w) begin
            ctl_a_r  <= rst_ctl_w;
            ctl_b_r  <= rst_ctl_w;
            ctl_io_r <= vwb_pkg::VWB_CTL_RST_32;
        end else if (apb_wr_w) begin
            if (hit_a_w)
                ctl_a_r <= wctl_w;
            if (hit_b_w)
                ctl_b_r <= '{1'b0, wctl_w.dsize, wctl_w.pwidth, wctl_w.waits};
            if (hit_io_w)
                ctl_io_r <= '{1'b0, vwb_pkg::VWB_W32, vwb_pkg::VWB_W32, wctl_w.waits};
        end
    end

endmodule : vwb_ext_bus
`default_nettype wire

// ===== vwb_ext_bus_assertions.sv
// checker of the external bus pins, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module vwb_ext_bus_assertions (
    // watched ports
    input wire logic       i_clk, i_rst_n, i_hold_n, i_ready_n, o_req_ack, o_data_oe_n, o_bus_oe_n,
    input wire logic       o_read_write, o_peripheral_strobe_n, o_bus_release_grant_n,
    input wire logic       o_bus_clock_phase_one, o_bus_clock_phase_three,
    input wire logic [3:0] o_bank_a_strobe_set
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [3:0] rdy_age_r;  // cycles since ready was low
    // saturating age of the ready input
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n) rdy_age_r <= 4'hf;
        else rdy_age_r <= !i_ready_n ? 4'h0 : rdy_age_r + {3'h0, rdy_age_r != 4'hf};
    a_write_rw_low: assert property (!o_data_oe_n |-> !o_read_write)
        else $error("rw high while driving data");
    a_read_rw_high: assert property (!o_bus_oe_n && o_data_oe_n && o_bank_a_strobe_set != 4'hf |-> o_read_write)
        else $error("rw low on read");
    a_release_float: assert property (!o_bus_release_grant_n |-> o_bus_oe_n && o_data_oe_n)
        else $error("bus driven while granted");
    a_grant_cause: assert property ($fell(o_bus_release_grant_n) |-> !$past(i_hold_n, 2))
        else $error("grant without request");
    a_grant_return: assert property ($rose(i_hold_n) |-> ##[1:8] o_bus_release_grant_n)
        else $error("grant stuck low");
    a_ack_after_ready: assert property (o_req_ack |-> rdy_age_r < 4'h8)
        else $error("ack without ready");
    a_strobe_min_len: assert property ($fell(o_bank_a_strobe_set[0]) |-> !o_bank_a_strobe_set[0] [*3])
        else $error("strobe too short");
    a_io_slow_strobe: assert property ($fell(o_peripheral_strobe_n) |-> !o_peripheral_strobe_n [*5])
        else $error("io strobe too short");
    a_bus_clock_pair: assert property (1'b1 |=> o_bus_clock_phase_one != $past(o_bus_clock_phase_one)
        && o_bus_clock_phase_one != o_bus_clock_phase_three) else $error("bus clocks wrong");
endmodule : vwb_ext_bus_assertions
bind vwb_ext_bus vwb_ext_bus_assertions chk_u (.*);
`default_nettype wire

// ===== vwb_mem_model.sv
// far side model: memory banks and peripheral answering the strobes
`timescale 1ns/1ps
`default_nettype none
module vwb_mem_model (
    // pins and delay selects
    input  wire logic        i_clk, i_rst_n, i_rw, i_per_n, i_wide, i_slow,
    input  wire logic [23:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_sa, i_sb,
    output logic             o_ready_n,
    output logic      [31:0] o_rdata
);
    logic [31:0] mem_r [16];
    logic [31:0] last_r;
    logic [2:0]  age_r;
    wire logic   act = !(&{i_sa[1:0], i_sb[1:0], i_per_n}) || (i_wide && !(&{i_sa[3:2], i_sb[3:2]}));
    // ready after a short or long delay, held until the strobe rises
    always @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n) begin
            age_r <= 3'h0;
            o_ready_n <= 1'b1;
            last_r <= 32'h0;
            for (int k = 0; k < 16; k++) mem_r[k] <= 32'h44332211 + 32'(k);
        end else begin
            age_r <= act ? age_r + {2'h0, age_r != 3'h7} : 3'h0;
            o_ready_n <= !(act && age_r >= (i_slow ? 3'h5 : 3'h1));
            if (act && !i_rw) mem_r[i_addr[3:0]] <= i_wdata;
            last_r <= o_rdata;
        end
    // idle data lines show the inverse of their last value
    assign o_rdata = (act && i_rw) ? mem_r[i_addr[3:0]] : ~last_r;
endmodule : vwb_mem_model
`default_nettype wire

// ===== vwb_pkg.sv
// constants and types of the external bus
package vwb_pkg;

    // ------------------------------------------------------------
    // width codes for memory width and data item size
    // ------------------------------------------------------------
    localparam logic [1:0] VWB_W8  = 2'h0;
    localparam logic [1:0] VWB_W16 = 2'h1;
    localparam logic [1:0] VWB_W32 = 2'h2;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] VWB_OFF_CTL_A  = 8'h00;
    localparam logic [7:0] VWB_OFF_CTL_B  = 8'h04;
    localparam logic [7:0] VWB_OFF_CTL_IO = 8'h08;
    localparam logic [7:0] VWB_OFF_STATUS = 8'h0c;

    // ------------------------------------------------------------
    // address map of the three strobes
    // ------------------------------------------------------------
    localparam logic [3:0] VWB_IO_REGION   = 4'h8;  // addr[23:20]
    localparam int         VWB_BANK_B_BIT  = 23;

    // ------------------------------------------------------------
    // timing counts in input clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] VWB_MIN_STROBE  = 4'h3;  // covers ready sync delay
    localparam logic [3:0] VWB_IO_EXTRA    = 4'h2;  // slower peripheral strobe
    localparam logic [1:0] VWB_INIT_LOAD   = 2'h2;  // strap sampled here

    // ------------------------------------------------------------
    // bus-control register layout, one per strobe
    // ------------------------------------------------------------
    typedef struct packed {
        logic       lockout;  // bit 7, meaningful in bank a only
        logic [1:0] dsize;    // bits 6:5 data item size
        logic [1:0] pwidth;   // bits 4:3 physical memory width
        logic [2:0] waits;    // bits 2:0 wait states
    } vwb_ctl_s;

    localparam vwb_ctl_s VWB_CTL_RST_32 = '{1'b0, VWB_W32, VWB_W32, 3'h7};
    localparam vwb_ctl_s VWB_CTL_RST_16 = '{1'b0, VWB_W32, VWB_W16, 3'h7};

    // ------------------------------------------------------------
    // cpu or dma request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] addr;   // item address
        logic [31:0] wdata;  // write item, low bits used
        logic        write;  // 1 write, 0 read
        logic        prog;   // program fetch
    } vwb_req_s;

    typedef enum logic [1:0] {VWB_SEL_A, VWB_SEL_B, VWB_SEL_IO} vwb_sel_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASED} vwb_state_e;

endpackage : vwb_pkg

// ===== vwb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module vwb_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // pin side and synchronised side
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // first flop feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RST;
            o_q    <= RST;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule : vwb_sync
`default_nettype wire
